// ==== lus_map.svh ====
// Functional notes
// - Transmit interrupt fires after each data byte and after the break field.
// - LIN reception exists only on this first channel pair, receive channel one.
// - Each received character holds eight data bits.
// - Received characters have no parity, one stop bit, LSB first.
// - Frame and overrun errors set flags and raise a receive error interrupt.
// - Receive polarity selectable: normal idles high, inverted idles low.
// - Receive input edge interrupt detects wake-up; software then arms width mode.
// - Timer starts on break falling edge, captures low width at rising edge.
// - After a valid break, timer captures falling-edge intervals up to the fourth.
// - Timer derives bit time by dividing captured sync length by its bit count.
// - Switch bits 0 and 1 route receive pin to edge interrupt and timer.
// - Break is byte 00 sent at nine thirteenths rate: thirteen low bit times.
// - Transmit wake-up is byte 80 sent at a chosen baud rate.
`ifndef LUS_MAP_SVH
`define LUS_MAP_SVH

// Clock and default line rate
`define LUS_CLK_HZ 10000000
`define LUS_BAUD_DEF 19200
`define LUS_DIV_DEF (`LUS_CLK_HZ / `LUS_BAUD_DEF)

// Register byte offsets
`define LUS_OFF_CTRL 8'h00
`define LUS_OFF_BAUD 8'h04
`define LUS_OFF_TXDATA 8'h08
`define LUS_OFF_RXDATA 8'h0c
`define LUS_OFF_STAT 8'h10
`define LUS_OFF_MASK 8'h14
`define LUS_OFF_CAP 8'h18
`define LUS_OFF_SYNC 8'h1c

// Control fields
`define LUS_CTRL_W 7
`define LUS_CTRL_EDGE 0
`define LUS_CTRL_TMR 1
`define LUS_CTRL_RXINV 2
`define LUS_CTRL_TXINV 3
`define LUS_CTRL_RUN 4
`define LUS_CTRL_TINT 5
`define LUS_CTRL_TEN 6
`define LUS_CTRL_RST 7'h00

// Status and mask fields
`define LUS_ST_W 7
`define LUS_ST_TXD 0
`define LUS_ST_RXD 1
`define LUS_ST_FE 2
`define LUS_ST_OVR 3
`define LUS_ST_WAKE 4
`define LUS_ST_CAP 5
`define LUS_ST_SYNC 6
`define LUS_MASK_RST 7'h00

// Data register fields
`define LUS_TX_BRK 8
`define LUS_TX_BUSY 9
`define LUS_RX_VALID 8

// Break rate scaling and sync field shape
`define LUS_BRK_NUM 13
`define LUS_BRK_DEN 9
`define LUS_SYNC_INTV 4
`define LUS_SYNC_BITS 8

// Bus answers
`define LUS_RESP_OK 2'h0
`define LUS_RESP_ERR 2'h2

`endif

// ==== lus_pkg.sv ====
`default_nettype none
package lus_pkg;
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA = 4'b0100,
		TX_STOP = 4'b1000
	} lus_tx_st_t;
	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} lus_rx_st_t;
endpackage : lus_pkg
`default_nettype wire

// ==== lus_uart_rx.sv ====
`default_nettype none
`include "lus_map.svh"
module lus_uart_rx #(
	parameter int DIV_W = 16
) (
	input wire logic i_clk, // System clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic i_rx, // Receive line, idle high
	input wire logic i_en, // Channel running
	input wire logic [DIV_W-1:0] i_div, // Clocks per bit
	output logic [7:0] o_data, // Received byte
	output logic o_done, // Character complete pulse
	output logic o_ferr // Stop bit low pulse
);
	import lus_pkg::*;
	lus_rx_st_t st;
	logic rx_prev;
	logic [DIV_W-1:0] cnt;
	logic [2:0] bitn;
	logic [7:0] sh;
	logic fall;
	logic bit_end;
	logic mid;

	assign fall = rx_prev & ~i_rx;
	assign bit_end = DIV_W'(cnt + 1'b1) >= i_div;
	assign mid = cnt >= (i_div >> 1);

	// Previous line level for start edge
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= i_rx;
		end
	end

	// 8N1 framing, samples taken mid-bit after a half-bit start check
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st <= RX_IDLE;
			cnt <= '0;
			bitn <= 3'h0;
			sh <= 8'h00;
			o_data <= 8'h00;
			o_done <= 1'b0;
			o_ferr <= 1'b0;
		end else begin
			o_done <= 1'b0;
			o_ferr <= 1'b0;
			if (!i_en) begin
				st <= RX_IDLE;
			end else begin
				unique case (st)
					RX_IDLE: begin
						cnt <= '0;
						if (fall) begin
							st <= RX_START;
						end
					end
					RX_START: begin
						if (mid) begin
							cnt <= '0;
							bitn <= 3'h0;
							// Glitch shorter than half a bit is dropped
							st <= i_rx ? RX_IDLE : RX_DATA;
						end else begin
							cnt <= DIV_W'(cnt + 1'b1);
						end
					end
					RX_DATA: begin
						if (bit_end) begin
							cnt <= '0;
							sh <= {i_rx, sh[7:1]};
							bitn <= 3'(bitn + 1'b1);
							if (bitn == 3'h7) begin
								st <= RX_STOP;
							end
						end else begin
							cnt <= DIV_W'(cnt + 1'b1);
						end
					end
					RX_STOP: begin
						if (bit_end) begin
							st <= RX_IDLE;
							o_data <= sh;
							o_done <= 1'b1;
							o_ferr <= ~i_rx;
						end else begin
							cnt <= DIV_W'(cnt + 1'b1);
						end
					end
				endcase
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	property p_rx_start;
		(st == RX_START && $past(st) == RX_IDLE) |-> $past(fall && i_en);
	endproperty
	a_rx_start: assert property (p_rx_start)
		else $error("receiver started without a falling edge");

	property p_rx_eight;
		(i_en && st == RX_DATA && bit_end && bitn == 3'h7) |=> st == RX_STOP;
	endproperty
	a_rx_eight: assert property (p_rx_eight)
		else $error("receiver did not stop after eight bits");
endmodule : lus_uart_rx
`default_nettype wire

// ==== lus_capture.sv ====
`default_nettype none
`include "lus_map.svh"
module lus_capture #(
	parameter int CNT_W = 16,
	parameter int INTV = `LUS_SYNC_INTV
) (
	input wire logic i_clk, // System clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic i_in, // Routed receive level
	input wire logic i_en, // Timer enabled
	input wire logic i_interval, // 1 interval mode, 0 width mode
	output logic [CNT_W-1:0] o_cap, // Last captured count
	output logic o_cap_stb, // Capture pulse
	output logic [CNT_W-1:0] o_bit, // Sync bit time
	output logic o_sync_stb // Sync measured pulse
);
	logic in_prev;
	logic run;
	logic armed;
	logic [CNT_W-1:0] cnt;
	logic [2:0] n;
	logic [CNT_W+2:0] total;
	logic [CNT_W+2:0] sum;
	logic fall;
	logic rise;

	assign fall = in_prev & ~i_in;
	assign rise = ~in_prev & i_in;
	assign sum = total + (CNT_W+3)'(cnt);

	// Counts in clocks; the counter saturates rather than wraps
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			in_prev <= 1'b1;
			run <= 1'b0;
			armed <= 1'b1;
			cnt <= '0;
			n <= 3'h0;
			total <= '0;
			o_cap <= '0;
			o_cap_stb <= 1'b0;
			o_bit <= '0;
			o_sync_stb <= 1'b0;
		end else begin
			in_prev <= i_in;
			o_cap_stb <= 1'b0;
			o_sync_stb <= 1'b0;
			if (!i_en) begin
				run <= 1'b0;
				armed <= 1'b1;
				n <= 3'h0;
				total <= '0;
			end else begin
				if (run && !(&cnt)) begin
					cnt <= CNT_W'(cnt + 1'b1);
				end
				if (!i_interval) begin
					if (fall) begin
						cnt <= CNT_W'(1);
						run <= 1'b1;
					end else if (rise && run) begin
						o_cap <= cnt;
						o_cap_stb <= 1'b1;
						run <= 1'b0;
					end
				end else if (fall && armed) begin
					cnt <= CNT_W'(1);
					run <= 1'b1;
					if (run) begin
						o_cap <= cnt;
						o_cap_stb <= 1'b1;
						total <= sum;
						n <= 3'(n + 1'b1);
						if (n == 3'(INTV - 1)) begin
							// Stops until re-enabled by software
							o_bit <= CNT_W'(sum / (CNT_W+3)'(`LUS_SYNC_BITS));
							o_sync_stb <= 1'b1;
							run <= 1'b0;
							armed <= 1'b0;
						end
					end
				end
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	property p_width_cap;
		(i_en && !i_interval && rise && run) |=> o_cap_stb && o_cap != '0;
	endproperty
	a_width_cap: assert property (p_width_cap)
		else $error("low width not captured at rising edge");

	property p_sync_count;
		o_sync_stb |-> $past(n) == 3'(INTV - 1) ##1 !o_sync_stb;
	endproperty
	a_sync_count: assert property (p_sync_count)
		else $error("sync ended on the wrong interval");

	property p_sync_bit;
		o_sync_stb |-> o_bit == CNT_W'($past(sum) >> 3);
	endproperty
	a_sync_bit: assert property (p_sync_bit)
		else $error("sync bit time is not length over bit count");
endmodule : lus_capture
`default_nettype wire

// ==== lus_top.sv ====
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`default_nettype none
`include "lus_map.svh"
module lus_top #(
	parameter int ADDR_W = 8,
	parameter int DIV_W = 16
) (
	input wire logic i_clk, // System clock, 10 MHz
	input wire logic i_rstn, // Async reset, active low
	input wire logic i_awvalid, // Write address valid
	output logic o_awready, // Write address ready
	input wire logic [ADDR_W-1:0] i_awaddr, // Write byte address
	input wire logic i_wvalid, // Write data valid
	output logic o_wready, // Write data ready
	input wire logic [31:0] i_wdata, // Write data
	input wire logic [3:0] i_wstrb, // Write byte lanes
	output logic o_bvalid, // Write response valid
	input wire logic i_bready, // Write response ready
	output logic [1:0] o_bresp, // Write response
	input wire logic i_arvalid, // Read address valid
	output logic o_arready, // Read address ready
	input wire logic [ADDR_W-1:0] i_araddr, // Read byte address
	output logic o_rvalid, // Read data valid
	input wire logic i_rready, // Read data ready
	output logic [31:0] o_rdata, // Read data
	output logic [1:0] o_rresp, // Read response
	input wire logic i_serial_rx_pin, // Receive pin
	output logic o_serial_tx_pin, // Transmit pin
	output logic o_irq, // Any unmasked status bit
	output logic o_tx_done_irq, // Byte or break sent
	output logic o_rx_done_irq, // Character received
	output logic o_rx_error_irq, // Frame or overrun error
	output logic o_wake_edge_irq // Receive edge seen
);
	import lus_pkg::*;

	localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(`LUS_DIV_DEF);
	localparam int PW = DIV_W + 4;

	// Bus slave state
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic rd_take;
	logic next_aw_held;
	logic next_w_held;
	logic next_bvalid;
	logic next_rvalid;
	logic [31:0] wm;
	logic [31:0] wv;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_word;

	// Registers
	logic [`LUS_CTRL_W-1:0] ctrl;
	logic [`LUS_ST_W-1:0] status;
	logic [`LUS_ST_W-1:0] next_status;
	logic [`LUS_ST_W-1:0] mask;
	logic [`LUS_ST_W-1:0] ev;
	logic [`LUS_ST_W-1:0] w1c;
	logic [DIV_W-1:0] div;
	logic [DIV_W-1:0] brk_div;
	logic [PW-1:0] brk_prod;

	// Receive path
	logic rx_s1;
	logic rx_s2;
	logic rx_line;
	logic rx_prev;
	logic rx_fall;
	logic tmr_in;
	logic [7:0] rx_data;
	logic rx_done;
	logic rx_ferr;
	logic [7:0] rx_byte;
	logic rx_full;
	logic rx_clr;
	logic ovr;
	logic [15:0] cap_val;
	logic cap_stb;
	logic [15:0] sync_bit;
	logic sync_stb;

	// Transmit path
	lus_tx_st_t tx_st;
	logic [DIV_W-1:0] tx_cnt;
	logic [DIV_W-1:0] tx_div;
	logic [2:0] tx_bit;
	logic [7:0] tx_sh;
	logic tx_brk;
	logic tx_done;
	logic tx_end;
	logic tx_go;
	logic tx_lvl;

	// Byte lanes apply to every writable field
	assign wm = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
		{8{w_strb[0]}}};
	assign wv = w_data & wm;

	// Handshake bookkeeping; AW and W may arrive in either order
	always_comb begin
		do_write = aw_held & w_held & ~o_bvalid;
		next_aw_held = do_write ? 1'b0 : (aw_held | (o_awready & i_awvalid));
		next_w_held = do_write ? 1'b0 : (w_held | (o_wready & i_wvalid));
		next_bvalid = do_write | (o_bvalid & ~i_bready);
		rd_take = o_arready & i_arvalid;
		next_rvalid = rd_take | (o_rvalid & ~i_rready);
	end

	// Write channel flops
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= `LUS_RESP_OK;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			if (o_awready && i_awvalid) begin
				aw_addr <= i_awaddr;
			end
			if (o_wready && i_wvalid) begin
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			// Ready stays low while a response waits, one write at a time
			o_awready <= ~next_aw_held & ~next_bvalid;
			o_wready <= ~next_w_held & ~next_bvalid;
			o_bvalid <= next_bvalid;
			if (do_write) begin
				o_bresp <= wr_hit ? `LUS_RESP_OK : `LUS_RESP_ERR;
			end
		end
	end

	// Write address decode
	always_comb begin
		unique case (aw_addr)
			`LUS_OFF_CTRL, `LUS_OFF_BAUD, `LUS_OFF_TXDATA, `LUS_OFF_RXDATA,
			`LUS_OFF_STAT, `LUS_OFF_MASK, `LUS_OFF_CAP,
			`LUS_OFF_SYNC: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Read mux; misaligned or unmapped addresses answer SLVERR with zero
	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h0;
		unique case (i_araddr)
			`LUS_OFF_CTRL: rd_word[`LUS_CTRL_W-1:0] = ctrl;
			`LUS_OFF_BAUD: rd_word[DIV_W-1:0] = div;
			`LUS_OFF_TXDATA: rd_word[`LUS_TX_BUSY] = (tx_st != TX_IDLE);
			`LUS_OFF_RXDATA: begin
				rd_word[7:0] = rx_byte;
				rd_word[`LUS_RX_VALID] = rx_full;
			end
			`LUS_OFF_STAT: rd_word[`LUS_ST_W-1:0] = status;
			`LUS_OFF_MASK: rd_word[`LUS_ST_W-1:0] = mask;
			`LUS_OFF_CAP: rd_word[15:0] = cap_val;
			`LUS_OFF_SYNC: rd_word[15:0] = sync_bit;
			default: rd_hit = 1'b0;
		endcase
	end

	// Read channel flops, data registered at the address handshake
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= `LUS_RESP_OK;
		end else begin
			o_arready <= ~next_rvalid;
			o_rvalid <= next_rvalid;
			if (rd_take) begin
				o_rdata <= rd_word;
				o_rresp <= rd_hit ? `LUS_RESP_OK : `LUS_RESP_ERR;
			end
		end
	end

	// Software registers
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl <= `LUS_CTRL_RST;
			mask <= `LUS_MASK_RST;
			div <= DIV_RST;
		end else if (do_write) begin
			unique case (aw_addr)
				`LUS_OFF_CTRL: ctrl <= (ctrl & ~wm[`LUS_CTRL_W-1:0])
					| wv[`LUS_CTRL_W-1:0];
				`LUS_OFF_MASK: mask <= (mask & ~wm[`LUS_ST_W-1:0])
					| wv[`LUS_ST_W-1:0];
				`LUS_OFF_BAUD: begin
					// Rate changes only while halted, never mid-character
					if (!ctrl[`LUS_CTRL_RUN]) begin
						div <= (div & ~wm[DIV_W-1:0]) | wv[DIV_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Two-flop synchroniser on the pin, then polarity select
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_s1 <= i_serial_rx_pin;
			rx_s2 <= rx_s1;
			rx_prev <= rx_line;
		end
	end

	// Flipping polarity may itself look like an edge; set it while halted
	assign rx_line = rx_s2 ^ ctrl[`LUS_CTRL_RXINV];
	assign rx_fall = rx_prev & ~rx_line;
	assign tmr_in = ctrl[`LUS_CTRL_TMR] ? rx_line : 1'b1;

	// Receive channel one of the first serial unit, the only LIN path
	lus_uart_rx #(
		.DIV_W(DIV_W)
	) u_rx (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_rx(rx_line),
		.i_en(ctrl[`LUS_CTRL_RUN]),
		.i_div(div),
		.o_data(rx_data),
		.o_done(rx_done),
		.o_ferr(rx_ferr)
	);

	// Width and interval timer on the routed receive line
	lus_capture #(
		.CNT_W(16),
		.INTV(`LUS_SYNC_INTV)
	) u_cap (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_in(tmr_in),
		.i_en(ctrl[`LUS_CTRL_TEN]),
		.i_interval(ctrl[`LUS_CTRL_TINT]),
		.o_cap(cap_val),
		.o_cap_stb(cap_stb),
		.o_bit(sync_bit),
		.o_sync_stb(sync_stb)
	);

	// Single holding byte; a new byte overwrites and flags overrun
	assign rx_clr = rd_take && (i_araddr == `LUS_OFF_RXDATA);
	assign ovr = rx_done & rx_full & ~rx_clr;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_byte <= 8'h00;
			rx_full <= 1'b0;
		end else if (rx_done) begin
			rx_byte <= rx_data;
			rx_full <= 1'b1;
		end else if (rx_clr) begin
			rx_full <= 1'b0;
		end
	end

	// Break uses 13/9 of the bit period so nine zero bits last 13 bits
	assign brk_prod = PW'(div) * PW'(`LUS_BRK_NUM);
	assign brk_div = DIV_W'(brk_prod / PW'(`LUS_BRK_DEN));
	assign tx_div = tx_brk ? brk_div : div;
	assign tx_end = DIV_W'(tx_cnt + 1'b1) >= tx_div;
	// Starts at once on write; any inter-segment gap is software's
	assign tx_go = do_write && (aw_addr == `LUS_OFF_TXDATA) && w_strb[0]
		&& ctrl[`LUS_CTRL_RUN] && (tx_st == TX_IDLE);

	// Transmit framer: start, eight data bits LSB first, one stop
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_st <= TX_IDLE;
			tx_cnt <= '0;
			tx_bit <= 3'h0;
			tx_sh <= 8'h00;
			tx_brk <= 1'b0;
			tx_done <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (!ctrl[`LUS_CTRL_RUN]) begin
				tx_st <= TX_IDLE;
			end else begin
				unique case (tx_st)
					TX_IDLE: begin
						tx_cnt <= '0;
						if (tx_go) begin
							tx_st <= TX_START;
							tx_brk <= wv[`LUS_TX_BRK];
							// Break forces byte 00; a wake-up is plain byte 80
							tx_sh <= wv[`LUS_TX_BRK] ? 8'h00 : wv[7:0];
						end
					end
					TX_START: begin
						if (tx_end) begin
							tx_cnt <= '0;
							tx_bit <= 3'h0;
							tx_st <= TX_DATA;
						end else begin
							tx_cnt <= DIV_W'(tx_cnt + 1'b1);
						end
					end
					TX_DATA: begin
						if (tx_end) begin
							tx_cnt <= '0;
							tx_sh <= {1'b0, tx_sh[7:1]};
							tx_bit <= 3'(tx_bit + 1'b1);
							if (tx_bit == 3'h7) begin
								tx_st <= TX_STOP;
							end
						end else begin
							tx_cnt <= DIV_W'(tx_cnt + 1'b1);
						end
					end
					TX_STOP: begin
						if (tx_end) begin
							tx_st <= TX_IDLE;
							tx_done <= 1'b1;
						end else begin
							tx_cnt <= DIV_W'(tx_cnt + 1'b1);
						end
					end
				endcase
			end
		end
	end

	// Line level by state, registered onto the pin with polarity
	always_comb begin
		unique case (tx_st)
			TX_START: tx_lvl = 1'b0;
			TX_DATA: tx_lvl = tx_sh[0];
			default: tx_lvl = 1'b1;
		endcase
	end
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_serial_tx_pin <= 1'b1;
		end else begin
			o_serial_tx_pin <= tx_lvl ^ ctrl[`LUS_CTRL_TXINV];
		end
	end

	// Event sources; a set in the clearing cycle wins
	always_comb begin
		ev = '0;
		ev[`LUS_ST_TXD] = tx_done;
		ev[`LUS_ST_RXD] = rx_done;
		ev[`LUS_ST_FE] = rx_ferr;
		ev[`LUS_ST_OVR] = ovr;
		ev[`LUS_ST_WAKE] = ctrl[`LUS_CTRL_EDGE] & rx_fall;
		ev[`LUS_ST_CAP] = cap_stb;
		ev[`LUS_ST_SYNC] = sync_stb;
		w1c = '0;
		if (do_write && aw_addr == `LUS_OFF_STAT) begin
			w1c = wv[`LUS_ST_W-1:0];
		end
		next_status = (status & ~w1c) | ev;
	end

	// Sticky status and interrupt outputs, one clock behind status
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			status <= '0;
			o_irq <= 1'b0;
			o_tx_done_irq <= 1'b0;
			o_rx_done_irq <= 1'b0;
			o_rx_error_irq <= 1'b0;
			o_wake_edge_irq <= 1'b0;
		end else begin
			status <= next_status;
			o_irq <= |(status & mask);
			o_tx_done_irq <= status[`LUS_ST_TXD] & mask[`LUS_ST_TXD];
			o_rx_done_irq <= status[`LUS_ST_RXD] & mask[`LUS_ST_RXD];
			o_rx_error_irq <= |(status[`LUS_ST_OVR:`LUS_ST_FE]
				& mask[`LUS_ST_OVR:`LUS_ST_FE]);
			o_wake_edge_irq <= status[`LUS_ST_WAKE] & mask[`LUS_ST_WAKE];
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_tx_last;
		ctrl[`LUS_CTRL_RUN] && tx_st == TX_STOP && tx_end;
	endsequence
	property p_tx_irq;
		s_tx_last |=> tx_done ##1 status[`LUS_ST_TXD];
	endproperty
	a_tx_irq: assert property (p_tx_irq)
		else $error("transmit done not flagged after stop bit");

	property p_brk_div;
		(PW'(brk_div) * PW'(9) <= brk_prod)
		&& (brk_prod < PW'(brk_div) * PW'(9) + PW'(9));
	endproperty
	a_brk_div: assert property (p_brk_div)
		else $error("break period is not 13/9 of a bit");

	property p_ferr;
		rx_ferr && mask[`LUS_ST_FE] |=> status[`LUS_ST_FE] ##1 o_rx_error_irq;
	endproperty
	a_ferr: assert property (p_ferr)
		else $error("frame error did not reach the error interrupt");

	property p_ovr;
		rx_done && rx_full && !rx_clr |=> status[`LUS_ST_OVR];
	endproperty
	a_ovr: assert property (p_ovr)
		else $error("overrun not flagged");

	property p_wake;
		ctrl[`LUS_CTRL_EDGE] && rx_fall |=> status[`LUS_ST_WAKE];
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake edge not flagged");

	property p_no_route;
		!ctrl[`LUS_CTRL_EDGE] && !status[`LUS_ST_WAKE] |=>
			!status[`LUS_ST_WAKE];
	endproperty
	a_no_route: assert property (p_no_route)
		else $error("wake flag set with edge route off");

	sequence s_wr_both;
		aw_held && w_held && !o_bvalid;
	endsequence
	property p_bresp;
		s_wr_both |=> o_bvalid and (!i_bready |=> o_bvalid);
	endproperty
	a_bresp: assert property (p_bresp)
		else $error("write response missing or dropped");
endmodule : lus_top
`default_nettype wire

// ==== lus_lin_master.sv ====
`default_nettype none
module lus_lin_master (
	input wire logic i_clk, // Bench clock
	output logic o_line // Bus level at the receive pin
);
	timeunit 1ns;
	timeprecision 1ns;
	int bit_clks = 8; // Clocks per bit, kept equal to the programmed rate
	logic inv = 1'b0; // Receiver polarity in use
	initial o_line = 1'b1;
	// Bits go out LSB first; idle is restored with a one clock gap so
	// that back-to-back calls never write the line twice in one step
	task automatic bits(input logic [15:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			o_line <= f[i] ^ inv;
			repeat (bit_clks) @(posedge i_clk);
		end
		o_line <= ~inv;
		@(posedge i_clk);
	endtask : bits
	// One character: start, eight data bits, chosen stop level
	task automatic send(input logic [7:0] d, input logic stp);
		bits({6'h00, stp, d, 1'b0}, 10);
	endtask : send
	// Break: n low bit times
	task automatic brk(input int n);
		bits(16'h0000, n);
	endtask : brk
	// Polarity change, only while the channel is halted
	task automatic set_inv(input logic v);
		inv = v;
		o_line <= ~v;
	endtask : set_inv
endmodule : lus_lin_master
`default_nettype wire

// ==== tb_lus_top.sv ====
`default_nettype none
`include "lus_map.svh"
`define LUS_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	failures++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_lus_top;
	timeunit 1ns;
	timeprecision 1ns;
	import lus_pkg::*;
	localparam int B = 8; // Short bit time keeps the run brief
	logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid, rx, tx, irq;
	logic txi, rxi, rei, wki;
	int failures = 0;
	int n_compared = 0;
	// Free running clock, 100 ns period
	always #50 clk = ~clk;
	lus_top dut_u (.i_clk(clk), .i_rstn(rstn), .i_awvalid(awvalid),
		.o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
		.o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
		.o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
		.o_rresp(rresp), .i_serial_rx_pin(rx), .o_serial_tx_pin(tx),
		.o_irq(irq), .o_tx_done_irq(txi), .o_rx_done_irq(rxi),
		.o_rx_error_irq(rei), .o_wake_edge_irq(wki));
	lus_lin_master lin_u (.i_clk(clk), .o_line(rx));
	task conclude;
		$display("Counts: failures %0d compared %0d", failures, n_compared);
		if (failures == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude
	// A spent wait bound ends the run
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			failures++;
			$display("Error wait expected answer seen timeout");
			conclude();
		end
	endtask : bound
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
			input logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= v;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 100);
		bready <= 1'b0;
		bound(n, 100);
		`LUS_CHK("bresp", e, bresp)
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 100);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		bound(n, 100);
	endtask : rd
	task automatic rc(input string nm, input logic [7:0] a,
			input logic [31:0] e, input logic [31:0] m = 32'hffffffff,
			input logic [1:0] er = 2'h0);
		rd(a);
		`LUS_CHK(nm, e, d & m)
		`LUS_CHK("rresp", er, r)
	endtask : rc
	// Lets the interrupt outputs catch up with status
	task automatic settle;
		repeat (2) @(posedge clk);
	endtask : settle
	// Sends one word and counts low clocks on the pin until done
	task automatic txm(input logic [31:0] v, input int lo, input int hi);
		int n;
		int c;
		n = 0;
		c = 0;
		wr(8'h08, v, 2'h0);
		while (txi !== 1'b1 && n < 3000) begin
			@(posedge clk);
			c += int'(tx === 1'b0);
			n++;
		end
		bound(n, 3000);
		`LUS_CHK("txlow", 1'b1, c >= lo && c <= hi)
		`LUS_CHK("txidle", 1'b1, tx)
	endtask : txm
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rc("ctrl", 8'h00, 32'h0);
		rc("baud", 8'h04, 32'h208);
		rc("mask", 8'h14, 32'h0);
		rc("hole", 8'h20, 32'h0, 32'hffffffff, 2'h2);
		wr(8'h20, 32'h1, 2'h2);
		wr(8'h04, B, 2'h0);
		wr(8'h14, 32'h7f, 2'h0);
		wr(8'h00, 32'h53, 2'h0);
		lin_u.brk(13);
		repeat (4 * B) @(posedge clk);
		rc("stat", 8'h10, 32'h36);
		`LUS_CHK("wake_irq", 1'b1, wki)
		`LUS_CHK("rx_irq", 1'b1, rxi)
		rd(8'h18);
		`LUS_CHK("cap", 1'b1, d >= 103 && d <= 105)
		// Drain the break's zero byte so the next one is no overrun
		rc("brk", 8'h0c, 32'h100, 32'h1ff);
		wr(8'h10, 32'h7f, 2'h0);
		settle();
		`LUS_CHK("irq", 1'b0, irq)
		wr(8'h00, 32'h13, 2'h0);
		wr(8'h00, 32'h73, 2'h0);
		lin_u.send(8'h55, 1'b1);
		settle();
		rc("sync", 8'h1c, 32'h8, 32'hffff);
		rc("stat", 8'h10, 32'h42, 32'h4e);
		rc("rx", 8'h0c, 32'h155, 32'h1ff);
		rc("rx", 8'h0c, 32'h055, 32'h1ff);
		wr(8'h10, 32'h7f, 2'h0);
		lin_u.send(8'h11, 1'b1);
		lin_u.send(8'h22, 1'b1);
		lin_u.send(8'h3c, 1'b0);
		settle();
		rc("stat", 8'h10, 32'h0e, 32'h0e);
		rc("rx", 8'h0c, 32'h13c, 32'h1ff);
		`LUS_CHK("err_irq", 1'b1, rei)
		wr(8'h14, 32'h01, 2'h0);
		settle();
		`LUS_CHK("err_irq", 1'b0, rei)
		`LUS_CHK("irq", 1'b0, irq)
		wr(8'h00, 32'h0, 2'h0);
		lin_u.set_inv(1'b1);
		wr(8'h00, 32'h14, 2'h0);
		lin_u.send(8'ha3, 1'b1);
		rc("rxinv", 8'h0c, 32'h1a3, 32'h1ff);
		wr(8'h00, 32'h0, 2'h0);
		lin_u.set_inv(1'b0);
		wr(8'h00, 32'h10, 2'h0);
		wr(8'h10, 32'h7f, 2'h0);
		txm(32'h080, 8 * B - 1, 8 * B + 1);
		wr(8'h10, 32'h7f, 2'h0);
		txm(32'h100, 90, 108);
		conclude();
	end
endmodule : tb_lus_top
`default_nettype wire
